// file: include/timer_unit_regs.vh
// Register offsets, field positions and reset values of the dual timer.
// Assumes an 8-bit register port with byte addresses as offsets.
`ifndef TIMER_UNIT_REGS_VH
`define TIMER_UNIT_REGS_VH

// ============================================================
// Register offsets
`define OFS_A_MODE      8'hd8
`define OFS_A_COUNT     8'hd9
`define OFS_B_MODE      8'hda
`define OFS_B_COUNT     8'hdb
`define OFS_B_RELOAD    8'hcd
`define OFS_IRQ_ENABLE  8'he0
`define OFS_IRQ_FLAGS   8'he1

// ============================================================
// Timer A mode fields
`define A_ENABLE_BIT    7
`define A_RATE_HI       6
`define A_RATE_LO       4
`define A_RTC_BIT       0
`define A_MODE_MASK     8'hf1

// ============================================================
// Timer B mode fields
`define B_ENABLE_BIT    7
`define B_RATE_HI       6
`define B_RATE_LO       4
`define B_CKSEL_BIT     3
`define B_ALOAD_BIT     2
`define B_TOUT_BIT      1
`define B_PWM_BIT       0

// ============================================================
// Interrupt enable and flag fields
`define IRQ_A_BIT       0
`define IRQ_B_BIT       1

// ============================================================
// Reset values and constants
`define RST_BYTE        8'h00
`define IRQ_VECTOR      8'h08
`define RTC_DIVIDE      7'h40
`define RTC_DIV_LAST    6'h3f
`define COUNT_FULL      8'hff

`endif

// file: verilog/pin_edge_sync.v
// Two-stage synchroniser with one-cycle edge pulse for an outside level.
// Assumes the pin is asynchronous to clk and slower than half its rate.
module pin_edge_sync #(
	parameter FALLING = 1
) (
	input  wire clk,
	input  wire rstn,
	input  wire pin,
	output reg  edge_pulse
);
	reg meta_r;
	reg sync_r;
	reg last_r;

	// Only sync_r and last_r feed the edge detector, never meta_r
	always @(posedge clk) begin
		if (!rstn) begin
			meta_r     <= 1'b0;
			sync_r     <= 1'b0;
			last_r     <= 1'b0;
			edge_pulse <= 1'b0;
		end else begin
			meta_r     <= pin;
			sync_r     <= meta_r;
			last_r     <= sync_r;
			if (FALLING != 0)
				edge_pulse <= last_r & ~sync_r;
			else
				edge_pulse <= ~last_r & sync_r;
		end
	end
endmodule // pin_edge_sync

// file: verilog/rate_prescaler.v
// Instruction-clock prescaler: tick every 256 >> sel cycles.
// Assumes clk is the instruction clock; restarts while run is low.
module rate_prescaler (
	input  wire       clk,
	input  wire       rstn,
	input  wire       run,
	input  wire [2:0] sel,
	output reg        tick
);
	reg  [7:0] div_r;
	wire [7:0] mask;

	// Code 0 divides by 256, code 7 by 2
	assign mask = 8'hff >> sel;

	always @(posedge clk) begin
		if (!rstn || !run) begin
			div_r <= 8'h00;
			tick  <= 1'b0;
		end else begin
			div_r <= div_r + 8'h01;
			tick  <= ((div_r & mask) == mask);
		end
	end
endmodule // rate_prescaler

// file: verilog/dual_8bit_timer_unit.v
// Dual 8-bit timer unit: basic timer A with RTC mode, timer B with
// reload, event counter, buzzer and PWM. clk is the instruction clock.
// Assumes the two pins are asynchronous; bus and green_mode are on clk.
// Behaviour
// - Timer A counts only while its mode enable bit 7 is set.
// - Timer A prescale code 0 divides by 256, code 7 by 2.
// - Timer A mode bit 0 selects RTC clock, else prescaled clock.
// - RTC clock is the 32768 Hz oscillator divided by 64.
// - In RTC mode prescale is ignored; full 256 counts per overflow.
// - Timer A overflow sets a sticky flag until software clears it.
// - Timer A has no reload; software rewrites count after overflow.
// - Timer B counts only while its enable bit is set.
// - Timer B overflows at ff, wrapping to 00 unless reloading, setting sticky flag.
// - Reload writes are buffered and loaded into count at overflow.
// - Reload follows auto-reload bit, forced on in PWM mode.
// - Enabled timer B overflow requests interrupt at vector 8.
// - In green mode timer B runs but never wakes the system.
// - Clock select 0: timer B counts prescaled instruction clock.
// - Clock select 1: timer B counts external pin, prescale ignored.
// - Event counting advances on falling edges of synchronised pin.
// - Without reload (auto-reload bit and PWM off) timer B spans 256 steps of the input clock.
// - Buzzer output toggles on every timer B overflow.
// - PWM cycle set by prescaler rate and reload contents.
`include "timer_unit_regs.vh"

module dual_8bit_timer_unit (
	input  wire       clk,
	input  wire       rstn,
	input  wire [7:0] addr,
	input  wire [7:0] wr_data,
	input  wire       wr_en,
	input  wire       rd_en,
	output reg  [7:0] rd_data,
	input  wire       rtc_osc_pin,
	input  wire       ext_count_pin,
	input  wire       green_mode,
	output reg        irq_req,
	output reg  [7:0] irq_vector,
	output reg        wake_req,
	output reg        wave_out,
	output reg        wave_oe
);

	// ============================================================
	// Register state
	reg  [7:0] timer_a_mode_reg;
	reg  [7:0] timer_a_count;
	reg  [7:0] timer_b_mode_reg;
	reg  [7:0] timer_b_count;
	reg  [7:0] reload_buf_r;
	reg  [7:0] timer_b_reload;
	reg        timer_a_irq_enable;
	reg        timer_b_irq_enable;
	reg        timer_a_overflow_flag;
	reg        timer_b_overflow_flag;
	reg  [5:0] rtc_div_r;
	reg        rtc_tick_r;
	reg        buzz_r;
	reg        pwm_r;

	// ============================================================
	// Decoded fields
	wire       timer_a_enable;
	wire [2:0] timer_a_prescale_sel;
	wire       timer_a_rtc_select;
	wire       timer_b_enable;
	wire [2:0] timer_b_prescale_sel;
	wire       timer_b_clock_select;
	wire       timer_b_autoreload_en;
	wire       timer_b_tout_en;
	wire       timer_b_pwm_en;

	assign timer_a_enable       = timer_a_mode_reg[`A_ENABLE_BIT];
	assign timer_a_prescale_sel =
		timer_a_mode_reg[`A_RATE_HI:`A_RATE_LO];
	assign timer_a_rtc_select   = timer_a_mode_reg[`A_RTC_BIT];
	assign timer_b_enable       = timer_b_mode_reg[`B_ENABLE_BIT];
	assign timer_b_prescale_sel =
		timer_b_mode_reg[`B_RATE_HI:`B_RATE_LO];
	assign timer_b_clock_select = timer_b_mode_reg[`B_CKSEL_BIT];
	assign timer_b_autoreload_en = timer_b_mode_reg[`B_ALOAD_BIT];
	assign timer_b_tout_en      = timer_b_mode_reg[`B_TOUT_BIT];
	assign timer_b_pwm_en       = timer_b_mode_reg[`B_PWM_BIT];

	// ============================================================
	// Write strobes
	wire wr_a_mode;
	wire wr_a_count;
	wire wr_b_mode;
	wire wr_b_count;
	wire wr_b_reload;
	wire wr_irq_en;
	wire wr_flags;

	// Exact decode; writes to any other address are dropped
	assign wr_a_mode   = wr_en && (addr == `OFS_A_MODE);
	assign wr_a_count  = wr_en && (addr == `OFS_A_COUNT);
	assign wr_b_mode   = wr_en && (addr == `OFS_B_MODE);
	assign wr_b_count  = wr_en && (addr == `OFS_B_COUNT);
	assign wr_b_reload = wr_en && (addr == `OFS_B_RELOAD);
	assign wr_irq_en   = wr_en && (addr == `OFS_IRQ_ENABLE);
	assign wr_flags    = wr_en && (addr == `OFS_IRQ_FLAGS);

	// ============================================================
	// Clock sources
	wire a_presc_tick;
	wire b_presc_tick;
	wire rtc_edge;
	wire ext_fall;

	// Prescalers restart on disable so the first period is whole
	rate_prescaler u_presc_a (
		.clk  (clk),
		.rstn (rstn),
		.run  (timer_a_enable & ~timer_a_rtc_select),
		.sel  (timer_a_prescale_sel),
		.tick (a_presc_tick)
	);

	rate_prescaler u_presc_b (
		.clk  (clk),
		.rstn (rstn),
		.run  (timer_b_enable & ~timer_b_clock_select),
		.sel  (timer_b_prescale_sel),
		.tick (b_presc_tick)
	);

	// Oscillator pin is asynchronous; count its rising edges
	pin_edge_sync #(.FALLING(0)) u_rtc_sync (
		.clk        (clk),
		.rstn       (rstn),
		.pin        (rtc_osc_pin),
		.edge_pulse (rtc_edge)
	);

	// External events count on falling edges after two flops
	pin_edge_sync #(.FALLING(1)) u_ext_sync (
		.clk        (clk),
		.rstn       (rstn),
		.pin        (ext_count_pin),
		.edge_pulse (ext_fall)
	);

	// Divide the oscillator edges by 64 for the RTC time base
	// The divider free-runs so its phase survives a timer A stop;
	// the first RTC step after enabling may come early
	always @(posedge clk) begin
		if (!rstn) begin
			rtc_div_r  <= 6'h00;
			rtc_tick_r <= 1'b0;
		end else begin
			rtc_tick_r <= 1'b0;
			if (rtc_edge) begin
				rtc_div_r  <= rtc_div_r + 6'h01;
				rtc_tick_r <= (rtc_div_r == `RTC_DIV_LAST);
			end
		end
	end

	// ============================================================
	// Timer A step and overflow
	wire a_tick;
	wire a_ovf;

	// RTC mode bypasses the prescale field entirely
	// No write guard: a count rewrite while the RTC runs shifts the
	// fixed interval, so software leaves the count alone there
	assign a_tick = timer_a_enable &&
		(timer_a_rtc_select ? rtc_tick_r : a_presc_tick);
	assign a_ovf  = a_tick && (timer_a_count == `COUNT_FULL);

	// ============================================================
	// Timer B step and overflow
	wire b_tick;
	wire b_ovf;
	wire b_reload_on;

	assign b_tick = timer_b_enable &&
		(timer_b_clock_select ? ext_fall : b_presc_tick);
	// Step from ff counts as overflow; without reload a full 256-step span, wrap ff to 00
	assign b_ovf  = b_tick && (timer_b_count == `COUNT_FULL);
	// PWM mode forces reload whenever the timer runs
	assign b_reload_on = timer_b_autoreload_en ||
		(timer_b_pwm_en && timer_b_enable);

	// ============================================================
	// Mode, enable and count registers
	// A software count write wins over a same-cycle step
	// so a count written on an overflow cycle skips the reload;
	// stop the timer before rewriting its count
	always @(posedge clk) begin
		if (!rstn) begin
			timer_a_mode_reg   <= `RST_BYTE;
			timer_a_count      <= `RST_BYTE;
			timer_b_mode_reg   <= `RST_BYTE;
			timer_b_count      <= `RST_BYTE;
			timer_a_irq_enable <= 1'b0;
			timer_b_irq_enable <= 1'b0;
		end else begin
			if (wr_a_mode)
				timer_a_mode_reg <= wr_data & `A_MODE_MASK;
			if (wr_b_mode)
				timer_b_mode_reg <= wr_data;
			if (wr_irq_en) begin
				timer_a_irq_enable <= wr_data[`IRQ_A_BIT];
				timer_b_irq_enable <= wr_data[`IRQ_B_BIT];
			end
			// No reload for A: it simply wraps to zero
			if (wr_a_count)
				timer_a_count <= wr_data;
			else if (a_tick)
				timer_a_count <= timer_a_count + 8'h01;
			if (wr_b_count)
				timer_b_count <= wr_data;
			else if (b_ovf && b_reload_on)
				timer_b_count <= reload_buf_r;
			else if (b_tick)
				timer_b_count <= timer_b_count + 8'h01;
		end
	end

	// ============================================================
	// Double-buffered reload
	// New value waits in the buffer and goes live only at overflow,
	// so a period in progress is never cut short
	// The count loads the buffer itself, so the period right after
	// the overflow already uses the new value
	always @(posedge clk) begin
		if (!rstn) begin
			reload_buf_r   <= `RST_BYTE;
			timer_b_reload <= `RST_BYTE;
		end else begin
			if (wr_b_reload)
				reload_buf_r <= wr_data;
			if (b_ovf)
				timer_b_reload <= reload_buf_r;
		end
	end

	// ============================================================
	// Sticky overflow flags
	// Writing 0 to a flag bit clears it; a new overflow wins
	// Writing 1 keeps a flag, so clearing one timer's flag leaves
	// the other untouched
	always @(posedge clk) begin
		if (!rstn) begin
			timer_a_overflow_flag <= 1'b0;
			timer_b_overflow_flag <= 1'b0;
		end else begin
			if (a_ovf)
				timer_a_overflow_flag <= 1'b1;
			else if (wr_flags && !wr_data[`IRQ_A_BIT])
				timer_a_overflow_flag <= 1'b0;
			if (b_ovf)
				timer_b_overflow_flag <= 1'b1;
			else if (wr_flags && !wr_data[`IRQ_B_BIT])
				timer_b_overflow_flag <= 1'b0;
		end
	end

	// ============================================================
	// Interrupt request and wake-up
	// Only timer A wakes from green mode; timer B keeps running
	// there but its overflow never raises a wake request
	// The vector is constant but registered, so every output of
	// the block comes from a flop
	always @(posedge clk) begin
		if (!rstn) begin
			irq_req    <= 1'b0;
			irq_vector <= `RST_BYTE;
			wake_req   <= 1'b0;
		end else begin
			irq_req    <= (timer_a_irq_enable & timer_a_overflow_flag)
				| (timer_b_irq_enable & timer_b_overflow_flag);
			irq_vector <= `IRQ_VECTOR;
			wake_req   <= green_mode & a_ovf;
		end
	end

	// ============================================================
	// Buzzer and PWM waveforms
	// Both toggle at overflow; the period is set by the prescale
	// rate and the live reload value, duty stays at one half
	always @(posedge clk) begin
		if (!rstn) begin
			buzz_r <= 1'b0;
			pwm_r  <= 1'b0;
		end else begin
			if (b_ovf)
				buzz_r <= ~buzz_r;
			if (!timer_b_pwm_en || !timer_b_enable)
				pwm_r <= 1'b0;
			else if (b_ovf)
				pwm_r <= ~pwm_r;
		end
	end

	// Output pin: PWM takes precedence over the buzzer toggle
	// The pin is released whenever neither PWM nor buzzer is on
	always @(posedge clk) begin
		if (!rstn) begin
			wave_out <= 1'b0;
			wave_oe  <= 1'b0;
		end else begin
			wave_oe  <= timer_b_pwm_en | timer_b_tout_en;
			wave_out <= timer_b_pwm_en ? pwm_r :
				(timer_b_tout_en & buzz_r);
		end
	end

	// ============================================================
	// Register read port
	// Data stands one cycle after the strobe; reload is write-only
	// and unmapped addresses read zero
	// Reads have no side effects: flags clear only by writes
	always @(posedge clk) begin
		if (!rstn) begin
			rd_data <= `RST_BYTE;
		end else if (!rd_en) begin
			rd_data <= `RST_BYTE;
		end else if (addr == `OFS_A_MODE) begin
			rd_data <= timer_a_mode_reg;
		end else if (addr == `OFS_A_COUNT) begin
			rd_data <= timer_a_count;
		end else if (addr == `OFS_B_MODE) begin
			rd_data <= timer_b_mode_reg;
		end else if (addr == `OFS_B_COUNT) begin
			rd_data <= timer_b_count;
		end else if (addr == `OFS_IRQ_ENABLE) begin
			rd_data <= {6'h00, timer_b_irq_enable, timer_a_irq_enable};
		end else if (addr == `OFS_IRQ_FLAGS) begin
			rd_data <= {6'h00, timer_b_overflow_flag,
				timer_a_overflow_flag};
		end else begin
			rd_data <= `RST_BYTE;
		end
	end

endmodule // dual_8bit_timer_unit

// file: tb/dual_8bit_timer_unit_assertions.sv
// Port checks for the dual timer unit.
// Assumes one instruction clock and a synchronous active-low reset.
module dual_8bit_timer_unit_assertions (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic [7:0] rd_data,
	input wire logic       rtc_osc_pin,
	input wire logic       ext_count_pin,
	input wire logic       green_mode,
	input wire logic       irq_req,
	input wire logic [7:0] irq_vector,
	input wire logic       wake_req,
	input wire logic       wave_out,
	input wire logic       wave_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	// ======
	// Sequences
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	sequence read_of(logic [7:0] a);
		rd_en && addr == a;
	endsequence
	sequence mask_all;
		wr_en && addr == 8'he0 && wr_data[1:0] == 2'b00;
	endsequence
	sequence b_stop;
		wr_en && addr == 8'hda && !wr_data[7];
	endsequence
	// ======
	// Checks
	AST_VECTOR: assert property ($past(rstn) |-> irq_vector == 8'h08)
		else $error("irq vector wrong");
	AST_RD_IDLE: assert property (!$past(rd_en) |-> rd_data == 8'h00)
		else $error("read data outside read slot");
	AST_A_MODE_GAP: assert property (read_of(8'hd8) |=> rd_data[3:1] == 3'h0)
		else $error("unused mode bits read set");
	AST_RELOAD_WO: assert property (read_of(8'hcd) |=> rd_data == 8'h00)
		else $error("reload register readable");
	AST_IRQ_MASK: assert property (mask_all |-> ##2 !irq_req)
		else $error("irq with both enables off");
	AST_WAKE_GREEN: assert property (wake_req |-> $past(green_mode))
		else $error("wake outside green mode");
	AST_WAVE_OFF: assert property (!wave_oe |-> !wave_out)
		else $error("wave out while not driven");
	AST_B_HOLD: assert property (b_stop |-> ##3 $stable(wave_out) [*4])
		else $error("wave toggles while stopped");
endmodule // dual_8bit_timer_unit_assertions

bind dual_8bit_timer_unit dual_8bit_timer_unit_assertions chk_i (
	.clk(clk), .rstn(rstn), .addr(addr), .wr_data(wr_data),
	.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
	.rtc_osc_pin(rtc_osc_pin), .ext_count_pin(ext_count_pin),
	.green_mode(green_mode), .irq_req(irq_req), .irq_vector(irq_vector),
	.wake_req(wake_req), .wave_out(wave_out), .wave_oe(wave_oe));

// file: tb/tb_dual_8bit_timer_unit.sv
// Self-checking bench for the dual timer unit.
// Assumes an 8-bit register port and a 200 MHz instruction clock.
module tb_dual_8bit_timer_unit;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0;
	logic       rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic       wr_en = 1'b0;
	logic       rd_en = 1'b0;
	logic       rtc_osc_pin = 1'b0;
	logic       ext_count_pin = 1'b1;
	logic       green_mode = 1'b0;
	logic [7:0] rd_data;
	logic [7:0] irq_vector;
	logic       irq_req;
	logic       wake_req;
	logic       wave_out;
	logic       wave_oe;
	logic [7:0] exp_q[$];
	logic [7:0] msk_q[$];
	logic [7:0] last_rd;
	logic [7:0] m;
	logic       rd_pend = 1'b0;
	logic       w0;
	logic [7:0] regs[8] = '{8'hd8, 8'hd9, 8'hda, 8'hdb, 8'hcd, 8'he0,
		8'he1, 8'h00};
	logic [7:0] bm[4] = '{8'h84, 8'h80, 8'h81, 8'h82};
	logic [7:0] be[4] = '{8'h40, 8'h00, 8'h40, 8'h00};
	int         n_mismatch = 0;
	int         check_count = 0;
	int         seed = 50615;
	int         i;
	int         n;
	int         t;
	int         wk = 0;

	dual_8bit_timer_unit uut (
		.clk(clk), .rstn(rstn), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.rtc_osc_pin(rtc_osc_pin), .ext_count_pin(ext_count_pin),
		.green_mode(green_mode), .irq_req(irq_req),
		.irq_vector(irq_vector), .wake_req(wake_req),
		.wave_out(wave_out), .wave_oe(wave_oe));

	// ======
	// Compare and bus tasks
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] s);
		check_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic chkp(input string nm, input logic e, input logic s);
		check_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %s expected %b seen %b", nm, e, s);
		end
	endtask
	// A gap cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		@(posedge clk);
	endtask
	// Mask zero marks a poll whose value is not compared
	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input logic [7:0] mk);
		addr <= a;
		rd_en <= 1'b1;
		exp_q.push_back(e);
		msk_q.push_back(mk);
		@(posedge clk);
		rd_en <= 1'b0;
		@(posedge clk);
		last_rd = rd_data;
	endtask
	task automatic poll(input int b);
		t = 0;
		do begin
			rd(8'he1, 8'h00, 8'h00);
			t += 2;
		end while (!last_rd[b] && t < 2000);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ======
	// Clock, watchdog and read monitor
	always #2.5 clk = ~clk;
	initial begin
		#100000;
		n_mismatch++;
		end_of_test();
	end
	always @(posedge clk) begin
		if (rd_pend) begin
			m = msk_q.pop_front();
			if (m != 8'h00)
				chk("rd_data", exp_q.pop_front() & m, rd_data & m);
			else
				void'(exp_q.pop_front());
		end
		rd_pend <= rd_en;
		// Wake pulses stand one cycle, so count them as they pass
		if (wake_req)
			wk++;
	end

	// ======
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		green_mode <= 1'b1;
		@(posedge clk);
		for (i = 0; i < 8; i++)
			rd(regs[i], 8'h00, 8'hff);
		chkp("irq_req", 1'b0, irq_req);
		chk("irq_vector", 8'h08, irq_vector);
		// Every timer A prescale code, overflow from ff
		wr(8'he0, 8'h01);
		// Green mode only on odd codes: four wake pulses expected
		for (i = 0; i < 8; i++) begin
			green_mode <= i[0];
			wr(8'hd8, 8'h00);
			wr(8'hd9, 8'hff);
			wr(8'he1, 8'h00);
			wr(8'hd8, {1'b1, i[2:0], 4'h0});
			poll(0);
			n = 256 >> i;
			chkp("a_span", 1'b1, t >= n && t <= n + 6);
			chkp("irq_req", 1'b1, irq_req);
		end
		green_mode <= 1'b1;
		chk("wake_count", 8'h04, 8'(wk));
		wr(8'hd8, 8'h70);
		wr(8'hd9, 8'h5a);
		repeat (20) @(posedge clk);
		rd(8'hd9, 8'h5a, 8'hff);
		rd(8'he1, 8'h01, 8'h01);
		wr(8'he1, 8'hfe);
		rd(8'he1, 8'h00, 8'h01);
		chkp("irq_req", 1'b0, irq_req);
		// Timer B reload, wrap, buzzer and PWM; reload rewritten mid-run
		for (i = 0; i < 4; i++) begin
			wr(8'hda, 8'h00);
			wr(8'hcd, 8'hfe);
			wr(8'hdb, 8'hff);
			wr(8'he1, 8'h00);
			wr(8'hda, bm[i]);
			// Buzzer level carries over from earlier overflows, so
			// take the reference once the new mode shows on the pin
			wr(8'hcd, 8'h40);
			w0 = wave_out;
			poll(1);
			chkp("b_span", 1'b1, t >= 250 && t <= 262);
			rd(8'hdb, be[i], 8'hff);
			chkp("wave_oe", |bm[i][1:0], wave_oe);
			chkp("wave_out", w0 ^ (|bm[i][1:0]), wave_out);
		end
		chk("wake_count", 8'h04, 8'(wk));
		chkp("irq_req", 1'b0, irq_req);
		wr(8'he0, 8'h02);
		@(posedge clk);
		chkp("irq_req", 1'b1, irq_req);
		// Event counter: n+1 falling and n rising edges, random rate
		wr(8'hda, 8'h00);
		wr(8'hdb, 8'h00);
		n = 1 + {$random(seed)} % 20;
		wr(8'hda, {1'b1, 3'($random(seed)), 4'h8});
		repeat (n) begin
			ext_count_pin <= 1'b0;
			repeat (4) @(posedge clk);
			ext_count_pin <= 1'b1;
			repeat (4) @(posedge clk);
		end
		ext_count_pin <= 1'b0;
		repeat (8) @(posedge clk);
		rd(8'hdb, 8'(n + 1), 8'hff);
		// RTC clocking with a fast rate code that must be ignored
		wr(8'hd8, 8'h71);
		wr(8'hd9, 8'hfe);
		wr(8'he1, 8'h00);
		wr(8'hd8, 8'hf1);
		// Count is never written while the RTC runs
		repeat (130) begin
			rtc_osc_pin <= 1'b1;
			repeat (2) @(posedge clk);
			rtc_osc_pin <= 1'b0;
			repeat (2) @(posedge clk);
		end
		repeat (6) @(posedge clk);
		rd(8'hd9, 8'h00, 8'hff);
		rd(8'he1, 8'h01, 8'h01);
		chk("wake_count", 8'h05, 8'(wk));
		wr(8'he0, 8'h01);
		@(posedge clk);
		chkp("irq_req", 1'b1, irq_req);
		wr(8'he0, 8'h00);
		repeat (3) @(posedge clk);
		chkp("irq_req", 1'b0, irq_req);
		end_of_test();
	end
endmodule // tb_dual_8bit_timer_unit
